// >>> lcr_regs.sv
// Line calibration register bank with its calibration sequencer and APB slave.
`timescale 1ns/10ps
`default_nettype none

module lcr_regs #(
   parameter int ADDR_WIDTH = 12,
   parameter logic [15:0] STEP_CYCLES = lcr_pkg::STEP_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_WIDTH-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [7:0] MEAS_VALUE,
   output logic CAL_ACTIVE,
   output logic [3:0] CAL_STEP,
   output logic IRQ,
   output logic [4:0] RING_MISMATCH_VALUE,
   output logic [4:0] TIP_MISMATCH_VALUE,
   output logic [4:0] DIFF_GAIN_VALUE,
   output logic [4:0] COMMON_GAIN_VALUE,
   output logic [3:0] CURRENT_LIMIT_VALUE,
   output logic [3:0] MONITOR_OFFSET_ONE,
   output logic [3:0] MONITOR_OFFSET_TWO,
   output logic OUT_OFFSET_PLUS,
   output logic OUT_OFFSET_MINUS,
   output logic IN_OFFSET_PLUS,
   output logic IN_OFFSET_MINUS,
   output logic [7:0] AUDIO_OUT_OFFSET_VALUE,
   output logic [5:0] BALANCE_VALUE,
   output logic [3:0] PEAK_MONITOR_VALUE
);

   typedef enum logic {
      CAL_IDLE,
      CAL_MEASURE
   } lcr_cal_state_type;

   localparam int NR = lcr_pkg::NUM_RESULTS;
   localparam int NS = lcr_pkg::NUM_STEPS;
   localparam int NI = lcr_pkg::NUM_IRQ;

   // ==========================================================================
   // APB decode.
   // Registers sit on word addresses only; any other address or an unknown
   // index answers with an error and has no effect.
   wire logic [ADDR_WIDTH-3:0] word_index;
   wire logic [7:0] index;
   wire logic aligned;
   wire logic in_range;
   wire logic hit_ctrl_one;
   wire logic hit_ctrl_two;
   wire logic hit_result;
   wire logic hit_status;
   wire logic hit_mask;
   wire logic mapped;
   wire logic setup_phase;
   wire logic access_done;
   wire logic wr_en;
   wire logic rd_en;
   wire logic [3:0] res_sel;
   wire logic [7:0] wbyte;

   assign word_index = PADDR[ADDR_WIDTH-1:2];
   assign in_range = (word_index >> 8) == '0;
   assign index = word_index[7:0];
   assign aligned = PADDR[1:0] == 2'h0;
   assign hit_ctrl_one = index == lcr_pkg::IDX_CAL_CONTROL_ONE;
   assign hit_ctrl_two = index == lcr_pkg::IDX_CAL_CONTROL_TWO;
   assign hit_result = (index >= lcr_pkg::IDX_RING_MISMATCH)
                       && (index <= lcr_pkg::IDX_PEAK_MONITOR);
   assign hit_status = index == lcr_pkg::IDX_IRQ_STATUS;
   assign hit_mask = index == lcr_pkg::IDX_IRQ_MASK;
   assign mapped = aligned && in_range
                   && (hit_ctrl_one || hit_ctrl_two || hit_result || hit_status || hit_mask);
   assign res_sel = 4'(index - lcr_pkg::IDX_RING_MISMATCH);
   assign setup_phase = PSEL && !PENABLE;
   assign access_done = PSEL && PENABLE;
   assign wr_en = access_done && PWRITE && mapped && PSTRB[0];
   assign rd_en = access_done && !PWRITE && mapped;
   assign wbyte = PWDATA[7:0];

   // No wait states: the read word is prepared in the setup cycle.
   assign PREADY = 1'b1;
   assign PSLVERR = access_done && !mapped;

   // ==========================================================================
   // State.
   lcr_cal_state_type state;
   logic [NS-1:0] pend;
   logic run;
   logic global_busy;
   logic [3:0] cur_step;
   logic [15:0] count;
   logic [7:0] res [0:NR-1];
   logic [NI-1:0] irq_status;
   logic [NI-1:0] irq_mask;
   logic [NI-1:0] read_snapshot;

   // ==========================================================================
   // Step selection and write effects on the calibration controls.
   logic [3:0] first_pend;
   logic any_pend;

   always_comb begin
      first_pend = 4'h0;
      any_pend = 1'b0;
      for (int s = NS - 1; s >= 0; s--) begin
         if (pend[s]) begin
            first_pend = 4'(s);
            any_pend = 1'b1;
         end
      end
   end

   wire logic wr_ctrl_one;
   wire logic wr_ctrl_two;
   wire logic global_start;
   wire logic local_start;
   wire logic step_done;
   wire logic run_over;
   wire logic [NS-1:0] wr_two_bits;
   wire logic [NS-1:0] wr_two_keep;

   assign wr_ctrl_one = wr_en && hit_ctrl_one;
   assign wr_ctrl_two = wr_en && hit_ctrl_two;
   assign global_start = wr_ctrl_one && wbyte[lcr_pkg::BIT_GLOBAL_CAL];
   // Only the three audio and balance bits start a run; the monitor bits only enable.
   assign local_start = wr_ctrl_two
                        && (wbyte[lcr_pkg::BIT_AUDIO_OUT_OFFSET_CAL]
                            || wbyte[lcr_pkg::BIT_AUDIO_IN_OFFSET_CAL]
                            || wbyte[lcr_pkg::BIT_BALANCE_CAL]);
   assign wr_two_bits = {wbyte[lcr_pkg::BIT_BALANCE_CAL],
                         wbyte[lcr_pkg::BIT_AUDIO_IN_OFFSET_CAL],
                         wbyte[lcr_pkg::BIT_AUDIO_OUT_OFFSET_CAL],
                         wbyte[lcr_pkg::BIT_MONITOR_CAL_TWO],
                         wbyte[lcr_pkg::BIT_MONITOR_CAL_ONE],
                         6'h00};
   assign wr_two_keep = {5'h00, 6'h3F};
   assign step_done = (state == CAL_MEASURE) && (count == 16'h0001);
   assign run_over = run && (state == CAL_IDLE) && !any_pend;

   logic [NS-1:0] next_pend;

   always_comb begin
      next_pend = pend;
      if (step_done) begin
         next_pend[cur_step] = 1'b0;
      end
      // A running step cannot be aborted, so its bit stays set until it ends.
      if (wr_ctrl_two) begin
         next_pend = (next_pend & wr_two_keep) | wr_two_bits;
         if (state == CAL_MEASURE && !step_done) begin
            next_pend[cur_step] = 1'b1;
         end
      end
      if (global_start) begin
         next_pend = next_pend | lcr_pkg::GLOBAL_STEPS;
      end
   end

   // ==========================================================================
   // Calibration sequencer.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pend <= lcr_pkg::PEND_RESET;
         run <= 1'b0;
         global_busy <= 1'b0;
         state <= CAL_IDLE;
         cur_step <= 4'h0;
         count <= 16'h0000;
      end else begin
         pend <= next_pend;
         if (global_start || local_start) begin
            run <= 1'b1;
         end else if (run_over) begin
            run <= 1'b0;
         end
         if (global_start) begin
            global_busy <= 1'b1;
         end else if (run_over) begin
            global_busy <= 1'b0;
         end
         case (state)
            CAL_IDLE: begin
               if (run && any_pend) begin
                  cur_step <= first_pend;
                  count <= STEP_CYCLES;
                  state <= CAL_MEASURE;
               end
            end
            CAL_MEASURE: begin
               count <= count - 16'h0001;
               if (step_done) begin
                  state <= CAL_IDLE;
               end
            end
            default: begin
               state <= CAL_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Result capture at the end of a step.
   logic [3:0] cap_reg;
   logic [7:0] cap_word;
   wire logic [7:0] cap_old;

   assign cap_old = res[cap_reg];

   always_comb begin
      cap_reg = 4'h0;
      cap_word = MEAS_VALUE;
      case (lcr_pkg::lcr_step_type'(cur_step))
         lcr_pkg::STEP_RING: cap_reg = 4'h0;
         lcr_pkg::STEP_TIP: cap_reg = 4'h1;
         lcr_pkg::STEP_DIFF: cap_reg = 4'h2;
         lcr_pkg::STEP_COMMON: cap_reg = 4'h3;
         lcr_pkg::STEP_LIMIT: cap_reg = 4'h4;
         lcr_pkg::STEP_PEAK: cap_reg = 4'h9;
         lcr_pkg::STEP_MONITOR_ONE: begin
            cap_reg = 4'h5;
            cap_word = {MEAS_VALUE[3:0], cap_old[3:0]};
         end
         lcr_pkg::STEP_MONITOR_TWO: begin
            cap_reg = 4'h5;
            cap_word = {cap_old[7:4], MEAS_VALUE[3:0]};
         end
         lcr_pkg::STEP_AUDIO_OUT: cap_reg = 4'h7;
         lcr_pkg::STEP_AUDIO_IN: begin
            // The input offset search settles the two input trim bits only.
            cap_reg = 4'h6;
            cap_word = {cap_old[7:2], MEAS_VALUE[1:0]};
         end
         lcr_pkg::STEP_BALANCE: cap_reg = 4'h8;
         default: cap_reg = 4'h0;
      endcase
   end

   // ==========================================================================
   // Result registers; a capture wins over a software write in the same cycle.
   for (genvar r = 0; r < NR; r++) begin : g_result
      wire logic cap_hit;
      wire logic wr_hit;

      assign cap_hit = step_done && (cap_reg == 4'(r));
      assign wr_hit = wr_en && hit_result && (res_sel == 4'(r));

      always_ff @(posedge CLK or posedge RST) begin
         if (RST) begin
            res[r] <= lcr_pkg::RES_RESET[r];
         end else if (cap_hit) begin
            res[r] <= cap_word & lcr_pkg::RES_MASK[r];
         end else if (wr_hit) begin
            res[r] <= wbyte & lcr_pkg::RES_MASK[r];
         end
      end
   end

   // ==========================================================================
   // Interrupts: one sticky bit per step end, plus one for the end of a run.
   // Reading the status clears only the bits that the read returned, so an
   // event arriving between setup and access is kept for the next read.
   logic [NI-1:0] irq_event;

   always_comb begin
      irq_event = '0;
      if (step_done) begin
         irq_event[cur_step] = 1'b1;
      end
      irq_event[NI-1] = run_over;
   end

   wire logic clear_status;
   wire logic wr_mask;

   assign clear_status = rd_en && hit_status;
   assign wr_mask = wr_en && hit_mask;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_status <= '0;
         irq_mask <= '0;
      end else begin
         irq_status <= (irq_status & ~(clear_status ? read_snapshot : '0)) | irq_event;
         if (wr_mask) begin
            irq_mask <= PWDATA[NI-1:0];
         end
      end
   end

   assign IRQ = |(irq_status & irq_mask);

   // ==========================================================================
   // Read path.
   logic [31:0] read_word;
   wire logic [7:0] ctrl_two_view;

   assign ctrl_two_view = {3'h0,
                           pend[lcr_pkg::STEP_MONITOR_ONE],
                           pend[lcr_pkg::STEP_MONITOR_TWO],
                           pend[lcr_pkg::STEP_AUDIO_OUT],
                           pend[lcr_pkg::STEP_AUDIO_IN],
                           pend[lcr_pkg::STEP_BALANCE]};

   always_comb begin
      read_word = 32'h0000_0000;
      if (hit_ctrl_one) begin
         read_word[lcr_pkg::BIT_GLOBAL_CAL] = global_busy;
      end else if (hit_ctrl_two) begin
         read_word[7:0] = ctrl_two_view;
      end else if (hit_result) begin
         read_word[7:0] = res[res_sel] & lcr_pkg::RES_MASK[res_sel];
      end else if (hit_status) begin
         read_word[NI-1:0] = irq_status;
      end else if (hit_mask) begin
         read_word[NI-1:0] = irq_mask;
      end
      if (!mapped) begin
         read_word = 32'h0000_0000;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
         read_snapshot <= '0;
      end else if (setup_phase && !PWRITE) begin
         PRDATA <= read_word;
         read_snapshot <= hit_status && mapped ? irq_status : '0;
      end
   end

   // ==========================================================================
   // Values handed to the analog front end.
   assign CAL_ACTIVE = state == CAL_MEASURE;
   assign CAL_STEP = cur_step;
   assign RING_MISMATCH_VALUE = res[0][4:0];
   assign TIP_MISMATCH_VALUE = res[1][4:0];
   assign DIFF_GAIN_VALUE = res[2][4:0];
   assign COMMON_GAIN_VALUE = res[3][4:0];
   assign CURRENT_LIMIT_VALUE = res[4][3:0];
   assign MONITOR_OFFSET_ONE = res[5][7:4];
   assign MONITOR_OFFSET_TWO = res[5][3:0];
   assign OUT_OFFSET_PLUS = res[6][3];
   assign OUT_OFFSET_MINUS = res[6][2];
   assign IN_OFFSET_PLUS = res[6][1];
   assign IN_OFFSET_MINUS = res[6][0];
   assign AUDIO_OUT_OFFSET_VALUE = res[7];
   assign BALANCE_VALUE = res[8][5:0];
   assign PEAK_MONITOR_VALUE = res[9][3:0];

endmodule

`default_nettype wire

// >>> lcr_pkg.sv
// Package with register map, field layout, reset values and timing of the line calibration bank.
package lcr_pkg;

   // ==========================================================================
   // Register indices; the byte address of each register is four times its index.
   localparam logic [7:0] IDX_CAL_CONTROL_ONE = 8'h60;
   localparam logic [7:0] IDX_CAL_CONTROL_TWO = 8'h61;
   localparam logic [7:0] IDX_RING_MISMATCH = 8'h62;
   localparam logic [7:0] IDX_TIP_MISMATCH = 8'h63;
   localparam logic [7:0] IDX_DIFF_GAIN = 8'h64;
   localparam logic [7:0] IDX_COMMON_GAIN = 8'h65;
   localparam logic [7:0] IDX_CURRENT_LIMIT = 8'h66;
   localparam logic [7:0] IDX_MONITOR_OFFSET = 8'h67;
   localparam logic [7:0] IDX_ANALOG_OFFSET = 8'h68;
   localparam logic [7:0] IDX_AUDIO_OUT_OFFSET = 8'h69;
   localparam logic [7:0] IDX_BALANCE = 8'h6A;
   localparam logic [7:0] IDX_PEAK_MONITOR = 8'h6B;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h71;

   // ==========================================================================
   // Result registers, in index order from the ring mismatch register upward.
   localparam int NUM_RESULTS = 10;
   localparam logic [7:0] RES_MASK [0:NUM_RESULTS-1] = '{
      8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h3F, 8'h0F};
   localparam logic [7:0] RES_RESET [0:NUM_RESULTS-1] = '{
      8'h10, 8'h10, 8'h11, 8'h10, 8'h08, 8'h88, 8'h00, 8'h00, 8'h20, 8'h08};

   // ==========================================================================
   // Field positions.
   localparam int BIT_GLOBAL_CAL = 6;
   localparam int BIT_MONITOR_CAL_ONE = 4;
   localparam int BIT_MONITOR_CAL_TWO = 3;
   localparam int BIT_AUDIO_OUT_OFFSET_CAL = 2;
   localparam int BIT_AUDIO_IN_OFFSET_CAL = 1;
   localparam int BIT_BALANCE_CAL = 0;
   localparam logic [7:0] CAL_CONTROL_TWO_RESET = 8'h1F;

   // ==========================================================================
   // Calibration steps, run lowest number first.
   localparam int NUM_STEPS = 11;
   typedef enum logic [3:0] {
      STEP_RING, STEP_TIP, STEP_DIFF, STEP_COMMON, STEP_LIMIT, STEP_PEAK,
      STEP_MONITOR_ONE, STEP_MONITOR_TWO, STEP_AUDIO_OUT, STEP_AUDIO_IN, STEP_BALANCE
   } lcr_step_type;
   localparam logic [NUM_STEPS-1:0] PEND_RESET = 11'h7C0;
   localparam logic [NUM_STEPS-1:0] GLOBAL_STEPS = 11'h03F;
   localparam int NUM_IRQ = NUM_STEPS + 1;

   // ==========================================================================
   // Timing.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STEP_TIME_NS = 1000;
   localparam int STEP_CYCLES_CALC = (STEP_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [15:0] STEP_CYCLES = 16'(STEP_CYCLES_CALC < 1 ? 1 : STEP_CYCLES_CALC);

endpackage

// >>> lcr_regs_props.sv
// Concurrent checks on the ports of the line calibration register bank.
`timescale 1ns/10ps
`default_nettype none

module lcr_regs_props #(
   parameter int ADDR_WIDTH = 12,
   parameter logic [15:0] STEP_CYCLES = lcr_pkg::STEP_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_WIDTH-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic CAL_ACTIVE,
   input wire logic [4:0] RING_MISMATCH_VALUE,
   input wire logic [3:0] MONITOR_OFFSET_ONE,
   input wire logic [3:0] MONITOR_OFFSET_TWO,
   input wire logic OUT_OFFSET_PLUS,
   input wire logic OUT_OFFSET_MINUS,
   input wire logic IN_OFFSET_PLUS,
   input wire logic IN_OFFSET_MINUS,
   input wire logic [7:0] AUDIO_OUT_OFFSET_VALUE,
   input wire logic [5:0] BALANCE_VALUE,
   input wire logic [3:0] PEAK_MONITOR_VALUE
);
   // ==========================================================================
   // Helper logic.
   logic [15:0] act_cnt;
   wire logic acc = PSEL && PENABLE;
   wire logic rd_acc = acc && !PWRITE;
   // A capture wins over a same-cycle write, so write checks skip measuring cycles.
   wire logic wr_ok = acc && PWRITE && PSTRB[0] && !CAL_ACTIVE;
   wire logic [7:0] pw_byte = PWDATA[7:0];

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         act_cnt <= 16'h0000;
      end else if (CAL_ACTIVE) begin
         act_cnt <= act_cnt + 16'h0001;
      end else begin
         act_cnt <= 16'h0000;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // ==========================================================================
   // Properties.
   sequence step_over;
      CAL_ACTIVE ##1 !CAL_ACTIVE;
   endsequence

   chk_ready_high: assert property (acc |-> PREADY)
      else $error("ready low in access phase");
   chk_unaligned_err: assert property (acc && PADDR[1:0] != 2'b00 |-> PSLVERR)
      else $error("unaligned access without error");
   chk_err_access_only: assert property (!acc |-> !PSLVERR)
      else $error("error outside access phase");
   chk_step_length: assert property (step_over |-> act_cnt == STEP_CYCLES)
      else $error("step length wrong");
   chk_step_bound: assert property (CAL_ACTIVE |-> act_cnt < STEP_CYCLES)
      else $error("step overran");
   chk_ring_write: assert property (wr_ok && PADDR == 12'h188 |=>
      RING_MISMATCH_VALUE == 5'($past(pw_byte)))
      else $error("ring field not written");
   chk_monitor_split: assert property (wr_ok && PADDR == 12'h19C |=>
      {MONITOR_OFFSET_ONE, MONITOR_OFFSET_TWO} == $past(pw_byte))
      else $error("monitor nibbles wrong");
   chk_trim_order: assert property (wr_ok && PADDR == 12'h1A0 |=>
      {OUT_OFFSET_PLUS, OUT_OFFSET_MINUS, IN_OFFSET_PLUS, IN_OFFSET_MINUS}
      == 4'($past(pw_byte)))
      else $error("trim bit order wrong");
   chk_results_hold: assert property (!CAL_ACTIVE && !(acc && PWRITE) |=>
      $stable(BALANCE_VALUE) && $stable(AUDIO_OUT_OFFSET_VALUE)
      && $stable(PEAK_MONITOR_VALUE))
      else $error("result changed without cause");
   chk_read_upper: assert property (rd_acc && PADDR >= 12'h184 && PADDR <= 12'h1AC
      |-> PRDATA[31:8] == 24'h000000)
      else $error("upper read bits set");
   chk_balance_upper: assert property (rd_acc && PADDR == 12'h1A8
      |-> PRDATA[7:6] == 2'b00)
      else $error("balance upper bits set");
   chk_peak_upper: assert property (rd_acc && PADDR == 12'h1AC
      |-> PRDATA[7:4] == 4'h0)
      else $error("peak upper bits set");
endmodule

bind lcr_regs lcr_regs_props #(.ADDR_WIDTH(ADDR_WIDTH), .STEP_CYCLES(STEP_CYCLES)) u_props (
   .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .CAL_ACTIVE(CAL_ACTIVE), .RING_MISMATCH_VALUE(RING_MISMATCH_VALUE),
   .MONITOR_OFFSET_ONE(MONITOR_OFFSET_ONE), .MONITOR_OFFSET_TWO(MONITOR_OFFSET_TWO),
   .OUT_OFFSET_PLUS(OUT_OFFSET_PLUS), .OUT_OFFSET_MINUS(OUT_OFFSET_MINUS),
   .IN_OFFSET_PLUS(IN_OFFSET_PLUS), .IN_OFFSET_MINUS(IN_OFFSET_MINUS),
   .AUDIO_OUT_OFFSET_VALUE(AUDIO_OUT_OFFSET_VALUE), .BALANCE_VALUE(BALANCE_VALUE),
   .PEAK_MONITOR_VALUE(PEAK_MONITOR_VALUE));

`default_nettype wire

// >>> lcr_tb.sv
// Self-checking testbench for the line calibration register bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %s expected %h seen %h", nm, e, g); end end

module testbench;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, cal_active, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, cal_step, ilim, mon1, mon2, peak;
   logic [7:0] meas, dac;
   logic [4:0] ring, tip, diff, comm;
   logic [5:0] bal;
   logic op, om, ip, im;
   int err_count = 0;
   int n_compared = 0;
   logic [7:0] rst_tab [0:10] = '{8'h1F, 8'h10, 8'h10, 8'h11, 8'h10, 8'h08, 8'h88, 8'h00,
      8'h00, 8'h20, 8'h08};
   logic [7:0] msk_tab [0:10] = '{8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'hFF, 8'h0F,
      8'hFF, 8'h3F, 8'h0F};

   lcr_regs #(.ADDR_WIDTH(12), .STEP_CYCLES(16'h0004)) u_dut (
      .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MEAS_VALUE(meas), .CAL_ACTIVE(cal_active), .CAL_STEP(cal_step), .IRQ(irq),
      .RING_MISMATCH_VALUE(ring), .TIP_MISMATCH_VALUE(tip), .DIFF_GAIN_VALUE(diff),
      .COMMON_GAIN_VALUE(comm), .CURRENT_LIMIT_VALUE(ilim), .MONITOR_OFFSET_ONE(mon1),
      .MONITOR_OFFSET_TWO(mon2), .OUT_OFFSET_PLUS(op), .OUT_OFFSET_MINUS(om),
      .IN_OFFSET_PLUS(ip), .IN_OFFSET_MINUS(im), .AUDIO_OUT_OFFSET_VALUE(dac),
      .BALANCE_VALUE(bal), .PEAK_MONITOR_VALUE(peak));

   // ==========================================================================
   // Bus tasks and the closing report.
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         err_count++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, rd)
   endtask

   // Polls a control register; the bound stands in for a hung sequencer.
   task automatic wait_clear(input logic [11:0] a);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0);
         n++;
      end while (rd !== 32'h0 && n < 100);
      if (n >= 100) begin
         err_count++;
         summarize();
      end
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (n >= 50) begin
         err_count++;
         summarize();
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ==========================================================================
   // Main sequence.
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      meas = 8'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 11; k++) rd_chk(12'h184 + 12'(4 * k), {24'h0, rst_tab[k]});
      rd_chk(12'h180, 32'h0);
      $display("test reset values done");
      for (int p = 0; p < 2; p++) begin
         for (int k = 1; k < 11; k++) begin
            apb(1'b1, 12'h184 + 12'(4 * k), p == 0 ? 32'hFF : 32'hA5);
            rd_chk(12'h184 + 12'(4 * k), {24'h0, (p == 0 ? 8'hFF : 8'hA5) & msk_tab[k]});
         end
      end
      `CHK("trim bits", 4'h5, {op, om, ip, im})
      `CHK("monitor nibbles", 8'hA5, {mon1, mon2})
      `CHK("balance port", 6'h25, bal)
      pstrb <= 4'hE;
      apb(1'b1, 12'h1A4, 32'h11);
      pstrb <= 4'hF;
      rd_chk(12'h1A4, 32'hA5);
      apb(1'b0, 12'h1B0, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      apb(1'b1, 12'h1A5, 32'h00);
      `CHK("unaligned error", 1'b1, err)
      rd_chk(12'h1A4, 32'hA5);
      `CHK("mapped error", 1'b0, err)
      $display("test fields done");
      apb(1'b1, 12'h1C4, 32'h800);
      meas <= 8'h3C;
      apb(1'b1, 12'h184, 32'h04);
      rd_chk(12'h184, 32'h04);
      wait_clear(12'h184);
      wait_irq();
      rd_chk(12'h1A4, 32'h3C);
      `CHK("out offset port", 8'h3C, dac)
      rd_chk(12'h1C0, 32'h900);
      @(negedge clk);
      `CHK("irq after clear", 1'b0, irq)
      rd_chk(12'h1C0, 32'h0);
      apb(1'b1, 12'h1C4, 32'h0);
      meas <= 8'h03;
      apb(1'b1, 12'h184, 32'h02);
      rd_chk(12'h184, 32'h02);
      wait_clear(12'h184);
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, 12'h1C4, 32'h800);
      @(negedge clk);
      `CHK("irq unmasked", 1'b1, irq)
      rd_chk(12'h1A0, 32'h07);
      rd_chk(12'h1C0, 32'hA00);
      @(negedge clk);
      `CHK("irq cleared", 1'b0, irq)
      meas <= 8'hFF;
      apb(1'b1, 12'h184, 32'h01);
      rd_chk(12'h184, 32'h01);
      wait_clear(12'h184);
      rd_chk(12'h1A8, 32'h3F);
      $display("test single calibrations done");
      apb(1'b1, 12'h184, 32'h18);
      rd_chk(12'h184, 32'h18);
      meas <= 8'h2B;
      apb(1'b1, 12'h180, 32'h40);
      rd_chk(12'h180, 32'h40);
      wait_clear(12'h180);
      rd_chk(12'h184, 32'h0);
      for (int k = 0; k < 6; k++) rd_chk(12'h188 + 12'(4 * k), k == 5 ? 32'hBB : 32'h0B);
      rd_chk(12'h1AC, 32'h0B);
      `CHK("ring port", 5'h0B, ring)
      `CHK("tip diff", {5'h0B, 5'h0B}, {tip, diff})
      `CHK("common limit", {5'h0B, 4'hB}, {comm, ilim})
      `CHK("peak port", 4'hB, peak)
      `CHK("last step", 4'h7, cal_step)
      rd_chk(12'h1C0, 32'hCFF);
      $display("test global calibration done");
      summarize();
   end
endmodule

`default_nettype wire
